//--- pkg/rls_pkg.sv
// Constants shared by the receive-link snapshot register bank.
package rls_pkg;
   localparam int          ADDR_W         = 9;
   localparam int          DATA_W         = 8;
   localparam int          SEL_W          = 3;
   // Register offsets.
   localparam logic [8:0]  OFF_CNT_CLEAR  = 9'h116;
   localparam logic [8:0]  OFF_LINK_SEL   = 9'h117;
   localparam logic [8:0]  OFF_GROUP_ID   = 9'h118;
   localparam logic [8:0]  OFF_CELL_OFS   = 9'h119;
   localparam logic [8:0]  OFF_FRAME_SEQ  = 9'h11a;
   localparam logic [8:0]  OFF_STAT_SEQ   = 9'h11b;
   localparam logic [8:0]  OFF_OOF_COUNT  = 9'h11c;
   localparam logic [8:0]  OFF_LINK_ID    = 9'h11d;
   localparam logic [8:0]  OFF_LINK_STATE = 9'h11e;
   localparam logic [8:0]  OFF_IRQ_STATUS = 9'h120;
   localparam logic [8:0]  OFF_IRQ_MASK   = 9'h121;
   // Reset values.
   localparam logic [7:0]  RST_GROUP_ID   = 8'h00;
   localparam logic [7:0]  RST_CELL_OFS   = 8'h00;
   localparam logic [7:0]  RST_FRAME_SEQ  = 8'h01;
   localparam logic [7:0]  RST_STAT_SEQ   = 8'h00;
   localparam logic [7:0]  RST_OOF_COUNT  = 8'h00;
   localparam logic [7:0]  RST_LINK_ID    = 8'h20;
   localparam logic [7:0]  RST_LINK_STATE = 8'h00;
   localparam logic [7:0]  RST_IRQ_MASK   = 8'h00;
   localparam logic [2:0]  RST_LINK_SEL   = 3'h0;
   // Link identity field positions.
   localparam int          LID_LOF_BIT    = 7;
   localparam int          LID_LOD_BIT    = 6;
   localparam int          LID_REF_BIT    = 5;
   localparam int          LID_NUM_MSB    = 4;
   // Link state field positions.
   localparam int          LST_FLEN_LSB   = 4;
   localparam int          LST_FRM_LSB    = 2;
   localparam int          LST_DEL_LSB    = 0;
   // Frame length codes.
   localparam logic [1:0]  FLEN_32        = 2'h0;
   localparam logic [1:0]  FLEN_64        = 2'h1;
   localparam logic [1:0]  FLEN_128       = 2'h2;
   localparam logic [1:0]  FLEN_256       = 2'h3;
   // Delineation state codes.
   localparam logic [1:0]  DSTATE_HUNT    = 2'h0;
   localparam logic [1:0]  DSTATE_PRESYNC = 2'h1;
   localparam logic [1:0]  DSTATE_SYNC    = 2'h2;
   localparam logic [1:0]  DSTATE_STUFF   = 2'h3;
   // Interrupt status bit positions and the counter ceiling.
   localparam int          IRQ_LOADED_BIT = 0;
   localparam int          IRQ_SAT_BIT    = 1;
   localparam int          IRQ_LOF_BIT    = 2;
   localparam logic [7:0]  CNT_MAX        = 8'hff;
endpackage

//--- src/rls_snapshot_regs.sv
// Receive-link snapshot register bank with per-link out-of-frame counters.
`timescale 1ns/10ps
module rls_snapshot_regs
   import rls_pkg::*;
#(
   parameter int NUM_LINKS = 8
) (
   input  wire logic                        ref_clk_i,
   input  wire logic                        rst_b_i,
   input  wire logic [ADDR_W-1:0]           addr_i,
   input  wire logic [DATA_W-1:0]           wr_data_i,
   input  wire logic                        wr_en_i,
   input  wire logic                        rd_en_i,
   output logic      [DATA_W-1:0]           rd_data_o,
   output logic                             irq_o,
   input  wire logic [NUM_LINKS-1:0][7:0]   group_identifier_i,
   input  wire logic [NUM_LINKS-1:0][7:0]   cell_offset_i,
   input  wire logic [NUM_LINKS-1:0][7:0]   frame_seq_i,
   input  wire logic [NUM_LINKS-1:0][7:0]   status_change_sequence_i,
   input  wire logic [NUM_LINKS-1:0]        out_of_frame_event_i,
   input  wire logic [NUM_LINKS-1:0]        loss_of_frame_state_i,
   input  wire logic [NUM_LINKS-1:0]        loss_of_delineation_state_i,
   input  wire logic [NUM_LINKS-1:0]        reference_link_i,
   input  wire logic [NUM_LINKS-1:0][4:0]   link_number_i,
   input  wire logic [NUM_LINKS-1:0][1:0]   frame_length_i,
   input  wire logic [NUM_LINKS-1:0][1:0]   frame_state_i,
   input  wire logic [NUM_LINKS-1:0][1:0]   delineation_state_i
);

   typedef struct packed {
      logic [SEL_W-1:0]               sel;
      logic [7:0]                     group_id;
      logic [7:0]                     cell_ofs;
      logic [7:0]                     frame_seq;
      logic [7:0]                     stat_seq;
      logic [7:0]                     oof_count;
      logic [7:0]                     link_id;
      logic [7:0]                     link_state;
      logic [NUM_LINKS-1:0][7:0]      counters;
      logic [7:0]                     irq_status;
      logic [7:0]                     irq_mask;
      logic [7:0]                     rdata;
   } rls_state_type;

   rls_state_type state_reg;
   rls_state_type state_next;

   logic [SEL_W-1:0] new_sel;
   logic             load;
   logic             clr_wr;
   logic             stat_rd;
   logic [7:0]       mux_group;
   logic [7:0]       mux_ofs;
   logic [7:0]       mux_fseq;
   logic [7:0]       mux_sseq;
   logic [7:0]       mux_count;
   logic [7:0]       mux_lid;
   logic [7:0]       mux_state;
   logic [7:0]       sat_now;

   // Keeps only the offset bits that a frame of the given length can use.
   function automatic logic [7:0] mask_offset(input logic [7:0] ofs, input logic [1:0] flen);
      logic [7:0] m;
      m = 8'hff;
      unique case (flen)
         FLEN_32:  m = 8'h1f;
         FLEN_64:  m = 8'h3f;
         FLEN_128: m = 8'h7f;
         FLEN_256: m = 8'hff;
      endcase
      return ofs & m;
   endfunction

   assign new_sel = wr_data_i[SEL_W-1:0];
   assign load    = wr_en_i && (addr_i == OFF_LINK_SEL);
   assign clr_wr  = wr_en_i && (addr_i == OFF_CNT_CLEAR);
   assign stat_rd = rd_en_i && (addr_i == OFF_IRQ_STATUS);

   // The snapshot is taken from the link named by the value being written, so software
   // sees the new link in the very first read after the select write.
   always_comb begin
      mux_group = group_identifier_i[new_sel];
      mux_ofs   = mask_offset(cell_offset_i[new_sel], frame_length_i[new_sel]);
      mux_fseq  = frame_seq_i[new_sel];
      mux_sseq  = status_change_sequence_i[new_sel];
      mux_count = state_reg.counters[new_sel];
      mux_lid   = {loss_of_frame_state_i[new_sel],
                   loss_of_delineation_state_i[new_sel],
                   reference_link_i[new_sel],
                   link_number_i[new_sel]};
      mux_state = {2'h0,
                   frame_length_i[new_sel],
                   frame_state_i[new_sel],
                   delineation_state_i[new_sel]};
   end

   always_comb begin
      state_next = state_reg;
      sat_now    = 8'h00;
      // Counters saturate so a long outage never wraps back to a small count.
      for (int k = 0; k < NUM_LINKS; k++) begin
         if (clr_wr && !wr_data_i[k]) begin
            state_next.counters[k] = 8'h00;
         end else if (out_of_frame_event_i[k] && state_reg.counters[k] != CNT_MAX) begin
            state_next.counters[k] = state_reg.counters[k] + 8'h01;
            if (state_reg.counters[k] == CNT_MAX - 8'h01) begin
               sat_now[k] = 1'b1;
            end
         end
      end
      // Only the select register can change the snapshot; writes elsewhere fall away.
      if (load) begin
         state_next.sel        = new_sel;
         state_next.group_id   = mux_group;
         state_next.cell_ofs   = mux_ofs;
         state_next.frame_seq  = mux_fseq;
         state_next.stat_seq   = mux_sseq;
         state_next.oof_count  = mux_count;
         state_next.link_id    = mux_lid;
         state_next.link_state = mux_state;
      end
      if (wr_en_i && addr_i == OFF_IRQ_MASK) begin
         state_next.irq_mask = wr_data_i;
      end
      // A read clears the status, but an event in the same cycle survives it.
      if (stat_rd) begin
         state_next.irq_status = 8'h00;
      end
      if (load) begin
         state_next.irq_status[IRQ_LOADED_BIT] = 1'b1;
         if (mux_lid[LID_LOF_BIT]) begin
            state_next.irq_status[IRQ_LOF_BIT] = 1'b1;
         end
      end
      if (|sat_now) begin
         state_next.irq_status[IRQ_SAT_BIT] = 1'b1;
      end
      state_next.rdata = 8'h00;
      if (rd_en_i) begin
         unique case (addr_i)
            OFF_LINK_SEL:   state_next.rdata = {5'h00, state_reg.sel};
            OFF_GROUP_ID:   state_next.rdata = state_reg.group_id;
            OFF_CELL_OFS:   state_next.rdata = state_reg.cell_ofs;
            OFF_FRAME_SEQ:  state_next.rdata = state_reg.frame_seq;
            OFF_STAT_SEQ:   state_next.rdata = state_reg.stat_seq;
            OFF_OOF_COUNT:  state_next.rdata = state_reg.oof_count;
            OFF_LINK_ID:    state_next.rdata = state_reg.link_id;
            OFF_LINK_STATE: state_next.rdata = state_reg.link_state;
            OFF_IRQ_STATUS: state_next.rdata = state_reg.irq_status;
            OFF_IRQ_MASK:   state_next.rdata = state_reg.irq_mask;
            default:        state_next.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_reg            <= '0;
         state_reg.sel        <= RST_LINK_SEL;
         state_reg.group_id   <= RST_GROUP_ID;
         state_reg.cell_ofs   <= RST_CELL_OFS;
         state_reg.frame_seq  <= RST_FRAME_SEQ;
         state_reg.stat_seq   <= RST_STAT_SEQ;
         state_reg.oof_count  <= RST_OOF_COUNT;
         state_reg.link_id    <= RST_LINK_ID;
         state_reg.link_state <= RST_LINK_STATE;
         state_reg.irq_mask   <= RST_IRQ_MASK;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rd_data_o = state_reg.rdata;
   assign irq_o     = |(state_reg.irq_status & state_reg.irq_mask);

   // Checks.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!rst_b_i);

   sequence seq_load;
      load;
   endsequence

   sequence seq_clear_sel;
      clr_wr && !wr_data_i[state_reg.sel] && !load;
   endsequence

   a_snapshot_hold: assert property (!load |=> $stable(state_reg.group_id)
      && $stable(state_reg.oof_count) && $stable(state_reg.link_id)
      && $stable(state_reg.link_state) && $stable(state_reg.frame_seq))
      else $error("Snapshot changed without a select write.");

   a_group_load: assert property (seq_load |=> state_reg.group_id == $past(mux_group))
      else $error("Group identifier not loaded from the selected link.");

   a_offset_width: assert property (
      (state_reg.link_state[5:4] == FLEN_32 |-> state_reg.cell_ofs[7:5] == 3'h0) and
      (state_reg.link_state[5:4] == FLEN_64 |-> state_reg.cell_ofs[7:6] == 2'h0) and
      (state_reg.link_state[5:4] == FLEN_128 |-> !state_reg.cell_ofs[7]))
      else $error("Cell offset holds bits beyond the frame length.");

   a_seq_load: assert property (seq_load |=>
      state_reg.frame_seq == $past(frame_seq_i[new_sel])
      && state_reg.stat_seq == $past(status_change_sequence_i[new_sel]))
      else $error("Sequence numbers not loaded from the selected link.");

   a_count_load: assert property (seq_load |=> state_reg.oof_count == $past(mux_count))
      else $error("Out-of-frame count not loaded from the selected counter.");

   a_identity_bits: assert property (seq_load |=>
      state_reg.link_id[LID_LOF_BIT] == $past(loss_of_frame_state_i[new_sel])
      && state_reg.link_id[LID_LOD_BIT] == $past(loss_of_delineation_state_i[new_sel])
      && state_reg.link_id[LID_REF_BIT] == $past(reference_link_i[new_sel])
      && state_reg.link_id[LID_NUM_MSB:0] == $past(link_number_i[new_sel]))
      else $error("Link identity bits do not match the selected link.");

   a_state_fields: assert property (seq_load |=> state_reg.link_state[7:6] == 2'h0
      && state_reg.link_state[5:4] == $past(frame_length_i[new_sel])
      && state_reg.link_state[3:0] == $past({frame_state_i[new_sel],
                                             delineation_state_i[new_sel]}))
      else $error("Link state register fields are wrong.");

   a_counter_clear: assert property (seq_clear_sel
      |=> state_reg.counters[$past(state_reg.sel)] == 8'h00)
      else $error("Cleared counter not reported as cleared.");

   a_write_ignored: assert property (wr_en_i && addr_i >= OFF_GROUP_ID
      && addr_i <= OFF_LINK_STATE |=> $stable(state_reg.group_id) && $stable(state_reg.cell_ofs))
      else $error("Write to a snapshot register changed it.");

   a_read_latency: assert property (rd_en_i && addr_i == OFF_LINK_ID
      |=> rd_data_o == $past(state_reg.link_id) ##1 rd_data_o == 8'h00 || $past(rd_en_i))
      else $error("Read data not presented one cycle after the strobe.");

   a_irq_level: assert property (stat_rd && !load && !(|sat_now) |=> !irq_o)
      else $error("Interrupt stays high after status read with no new event.");

   // Status bits follow a set-wins rule, so an event that meets a clearing read still lands.
   sequence seq_status_read;
      stat_rd;
   endsequence

   sequence seq_any_sat;
      |sat_now;
   endsequence

   sequence seq_mask_write;
      wr_en_i && addr_i == OFF_IRQ_MASK;
   endsequence

   a_select_stored: assert property (seq_load |=> state_reg.sel == $past(new_sel))
      else $error("Link select not stored on its write.");

   a_select_hold: assert property (!load |=> $stable(state_reg.sel))
      else $error("Link select changed without a write.");

   a_offset_load: assert property (seq_load |=>
      state_reg.cell_ofs == ($past(cell_offset_i[new_sel])
      & (($past(frame_length_i[new_sel]) == FLEN_32) ? 8'h1f :
         ($past(frame_length_i[new_sel]) == FLEN_64) ? 8'h3f :
         ($past(frame_length_i[new_sel]) == FLEN_128) ? 8'h7f : 8'hff)))
      else $error("Cell offset not masked to the frame length at load.");

   a_state_top_zero: assert property (state_reg.link_state[7:6] == 2'h0)
      else $error("Unused link state bits are not zero.");

   a_write_ignored_ids: assert property (wr_en_i && addr_i >= OFF_GROUP_ID
      && addr_i <= OFF_LINK_STATE |=> $stable(state_reg.link_id)
      && $stable(state_reg.link_state) && $stable(state_reg.oof_count))
      else $error("Write to a snapshot register changed identity or state.");

   a_loaded_flag: assert property (seq_load |=> state_reg.irq_status[IRQ_LOADED_BIT])
      else $error("Snapshot load did not set its status bit.");

   a_loss_flag: assert property (seq_load ##0 mux_lid[LID_LOF_BIT]
      |=> state_reg.irq_status[IRQ_LOF_BIT])
      else $error("Loss-of-frame load did not set its status bit.");

   a_sat_flag: assert property (seq_any_sat |=> state_reg.irq_status[IRQ_SAT_BIT])
      else $error("Counter reaching its ceiling did not set its status bit.");

   a_status_clear: assert property (seq_status_read ##0 (!load && !(|sat_now))
      |=> state_reg.irq_status == 8'h00)
      else $error("Status not cleared by its read.");

   a_mask_write: assert property (seq_mask_write |=> state_reg.irq_mask == $past(wr_data_i))
      else $error("Interrupt mask not stored on its write.");

   a_read_idle: assert property (!rd_en_i |=> rd_data_o == 8'h00)
      else $error("Read data not zero outside the read answer cycle.");

   // The clear register is write-only; a read of it must answer zero like a hole.
   a_clear_read_zero: assert property (rd_en_i && addr_i == OFF_CNT_CLEAR
      |=> rd_data_o == 8'h00)
      else $error("Counter-clear register read returned non-zero.");

   // Each link's counter is watched on its own, so a fault on one lane cannot hide.
   // Saturation matters because a long outage must not wrap to a small count.
   for (genvar g = 0; g < NUM_LINKS; g++) begin : gen_counter_checks
      a_count_saturate: assert property (state_reg.counters[g] == CNT_MAX
         && !(clr_wr && !wr_data_i[g]) |=> state_reg.counters[g] == CNT_MAX)
         else $error("Out-of-frame counter moved past its ceiling.");
      a_clear_wins: assert property (clr_wr && !wr_data_i[g]
         |=> state_reg.counters[g] == 8'h00)
         else $error("Counter clear lost to a same-cycle event.");
      a_count_step: assert property (out_of_frame_event_i[g] && !clr_wr
         && state_reg.counters[g] != CNT_MAX
         |=> state_reg.counters[g] == $past(state_reg.counters[g]) + 8'h01)
         else $error("Out-of-frame event did not advance the counter.");
      a_count_idle: assert property (!out_of_frame_event_i[g] && !clr_wr
         |=> $stable(state_reg.counters[g]))
         else $error("Counter changed with no event and no clear.");
   end

endmodule

//--- verification/test_rls_snapshot_regs.sv
// Self-checking testbench for the receive-link snapshot register bank.
`timescale 1ns/10ps
module test_rls_snapshot_regs
   import rls_pkg::*;
;
   logic                  ref_clk_i = 1'b0;
   logic                  rst_b_i   = 1'b0;
   logic [ADDR_W-1:0]     addr;
   logic [DATA_W-1:0]     wdata;
   logic                  wr_en;
   logic                  rd_en;
   logic [DATA_W-1:0]     rd_data;
   logic                  irq;
   logic [7:0][7:0]       gid, cofs, fseq, sseq;
   logic [7:0]            oof, lof, lod, refl;
   logic [7:0][4:0]       lnum;
   logic [7:0][1:0]       flen, fst, dst;
   logic [7:0]            snap [7];
   logic [7:0]            d;
   int                    cnt [8];
   int                    errors, num_checks, cycles;

   rls_snapshot_regs #(.NUM_LINKS(8)) u_rls_snapshot_regs (
      .ref_clk_i                   (ref_clk_i),
      .rst_b_i                     (rst_b_i),
      .addr_i                      (addr),
      .wr_data_i                   (wdata),
      .wr_en_i                     (wr_en),
      .rd_en_i                     (rd_en),
      .rd_data_o                   (rd_data),
      .irq_o                       (irq),
      .group_identifier_i          (gid),
      .cell_offset_i               (cofs),
      .frame_seq_i                 (fseq),
      .status_change_sequence_i    (sseq),
      .out_of_frame_event_i        (oof),
      .loss_of_frame_state_i       (lof),
      .loss_of_delineation_state_i (lod),
      .reference_link_i            (refl),
      .link_number_i               (lnum),
      .frame_length_i              (flen),
      .frame_state_i               (fst),
      .delineation_state_i         (dst)
   );

   always #2.5 ref_clk_i = ~ref_clk_i;

   // The whole sequence needs well under a thousand cycles.
   always @(posedge ref_clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         errors = errors + 1;
         $display("ERROR at %0t: run did not finish in time", $time);
         results();
      end
   end

   task automatic results();
      $display("Comparisons: %0d, mismatches: %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic chk8(input logic [7:0] act, input logic [7:0] exp);
      num_checks++;
      if (act !== exp) begin
         errors++;
         $display("ERROR at %0t: read %h, expected %h", $time, act, exp);
      end
   endtask

   task automatic chk1(input logic act, input logic exp);
      num_checks++;
      if (act !== exp) begin
         errors++;
         $display("ERROR at %0t: interrupt %b, expected %b", $time, act, exp);
      end
   endtask

   task automatic wr(input logic [8:0] a, input logic [7:0] v);
      @(posedge ref_clk_i);
      addr  <= a;
      wdata <= v;
      wr_en <= 1'b1;
      @(posedge ref_clk_i);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd(input logic [8:0] a, output logic [7:0] v);
      @(posedge ref_clk_i);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge ref_clk_i);
      rd_en <= 1'b0;
      #1;
      v = rd_data;
   endtask

   function automatic logic [7:0] exp_reg(input int k, input int i);
      logic [8:0] m;
      m = (9'h020 << flen[k]) - 9'h001;
      case (i)
         0: return gid[k];
         1: return cofs[k] & m[7:0];
         2: return fseq[k];
         3: return sseq[k];
         4: return 8'(cnt[k]);
         5: return {lof[k], lod[k], refl[k], lnum[k]};
         default: return {2'h0, flen[k], fst[k], dst[k]};
      endcase
   endfunction

   task automatic sel(input int k);
      for (int i = 0; i < 7; i++) snap[i] = exp_reg(k, i);
      wr(OFF_LINK_SEL, 8'(k));
   endtask

   task automatic check_bank();
      for (int i = 0; i < 7; i++) begin
         rd(OFF_GROUP_ID + 9'(i), d);
         chk8(d, snap[i]);
      end
   endtask

   initial begin
      addr = 9'h000; wdata = 8'h00; wr_en = 1'b0; rd_en = 1'b0;
      errors = 0; num_checks = 0; cycles = 0;
      oof = 8'h00; lof = 8'h55; lod = 8'h33; refl = 8'h20;
      for (int k = 0; k < 8; k++) begin
         gid[k] = 8'(8'ha0 + k); cofs[k] = 8'(8'hff - k); fseq[k] = 8'(k * 3 + 5);
         sseq[k] = 8'(8'hc0 + k); lnum[k] = 5'(31 - k * 3); flen[k] = 2'(k % 4);
         fst[k] = 2'((k + 1) % 4); dst[k] = 2'(k % 3); cnt[k] = 0;
      end
      repeat (16) @(posedge ref_clk_i);
      rst_b_i <= 1'b1;
      snap = '{RST_GROUP_ID, RST_CELL_OFS, RST_FRAME_SEQ, RST_STAT_SEQ,
               RST_OOF_COUNT, RST_LINK_ID, RST_LINK_STATE};
      check_bank();
      rd(9'h1ff, d);
      chk8(d, 8'h00);
      chk1(irq, 1'b0);
      // Every link in turn exercises all frame lengths and frame state codes, but delineation state codes 0 to 2 only.
      for (int k = 0; k < 8; k++) begin
         sel(k);
         check_bank();
      end
      @(posedge ref_clk_i);
      gid[7] <= 8'h00; lof <= ~lof; lnum[7] <= 5'h00; fst[7] <= 2'h3;
      check_bank();
      for (int i = 0; i < 7; i++) wr(OFF_GROUP_ID + 9'(i), 8'h5a);
      check_bank();
      for (int n = 0; n < 3; n++) begin
         @(posedge ref_clk_i);
         oof <= 8'h04;
         @(posedge ref_clk_i);
         oof <= 8'h00;
      end
      cnt[2] = 3;
      sel(2);
      check_bank();
      wr(OFF_CNT_CLEAR, 8'hfb);
      cnt[2] = 0;
      sel(2);
      check_bank();
      // Status is sticky from the loads above, so unmasking raises the line at once.
      wr(OFF_IRQ_MASK, 8'h01);
      #1;
      chk1(irq, 1'b1);
      rd(OFF_IRQ_STATUS, d);
      chk8(d, 8'h05);
      chk1(irq, 1'b0);
      rd(OFF_IRQ_STATUS, d);
      chk8(d, 8'h00);
      sel(1);
      #1;
      chk1(irq, 1'b1);
      rd(OFF_IRQ_STATUS, d);
      chk8(d, {5'h00, lof[1], 2'h1});
      wr(OFF_IRQ_MASK, 8'h00);
      sel(3);
      #1;
      chk1(irq, 1'b0);
      check_bank();
      // One pulse more than the ceiling shows the counter sticks at its top value.
      for (int n = 0; n < 256; n++) begin
         @(posedge ref_clk_i);
         oof <= 8'h20;
         @(posedge ref_clk_i);
         oof <= 8'h00;
      end
      cnt[5] = 255;
      sel(5);
      check_bank();
      rd(OFF_IRQ_STATUS, d);
      chk8(d, {5'h00, lof[5], 2'h3});
      results();
   end
endmodule
